/* File: rtl/plas_consts.svh */
// constants for the lane alignment status block
`ifndef PLAS_CONSTS_SVH
`define PLAS_CONSTS_SVH

// ------------------------------------------------------------
// lane count and link input bundle
// ------------------------------------------------------------
`define PLAS_LANE_COUNT   4
`define PLAS_IN_W         24

// ------------------------------------------------------------
// register byte offsets (ahb-lite, one word each)
// ------------------------------------------------------------
`define PLAS_OFF_CTRL     8'h00
`define PLAS_OFF_INTERVAL 8'h04
`define PLAS_OFF_STATUS   8'h08
`define PLAS_OFF_MAP      8'h0c
`define PLAS_OFF_ISTAT    8'h10
`define PLAS_OFF_IMASK    8'h14

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define PLAS_CTRL_TXEN    0
`define PLAS_IRQ_ALIGN    0
`define PLAS_IRQ_LOSS     1
`define PLAS_IRQ_TXFIFO   2
`define PLAS_IRQ_BIP      4
`define PLAS_IRQ_SPC      8
`define PLAS_MI_RST       16'h3fff

// ------------------------------------------------------------
// timing: high error rate window and threshold
// ------------------------------------------------------------
`define PLAS_CLK_MHZ      25
`define PLAS_HBER_WIN_NS  125000
`define PLAS_HBER_WIN_CYC ((`PLAS_HBER_WIN_NS * `PLAS_CLK_MHZ) / 1000)
`define PLAS_HBER_LIMIT   16

`endif

/* File: rtl/plas_pkg.sv */
// types for the lane alignment status block
`default_nettype none

package plas_pkg;

  // transmit encoder states
  typedef enum logic [0:0] {
    PLAS_TX_INIT,
    PLAS_TX_RUN
  } plas_tx_st_t;

  // state of one physical lane tracker
  typedef struct packed {
    logic [15:0] cnt;
    logic        seen;
    logic        found;
    logic        synced;
    logic        sync_err;
    logic [1:0]  id;
    logic        spc_err;
    logic        bip_err;
  } plas_lane_st_t;

  // state of the top module
  typedef struct packed {
    logic        lclk_s1, lclk_s2, lclk_p;
    logic [23:0] in_s1, in_s2;
    logic        dp, done, wr;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        txen;
    logic [15:0] mi;
    logic [11:0] istat, imask;
    logic [3:0]  found;
    logic [7:0]  map;
    logic        aligned, loss, aerr, hiber, pst;
    logic [3:0]  bip, spc, seen_acc, got;
    logic        started, miss;
    logic [6:0]  win;
    logic [11:0] btmr;
    logic [4:0]  bcnt;
    plas_tx_st_t txst;
    logic [4:0]  flvl;
    logic        ferr;
  } plas_top_st_t;

endpackage

`default_nettype wire

/* File: rtl/plas_lane_if.sv */
// signals between the top and one physical lane tracker
`default_nettype none

interface plas_lane_if;
  logic        word;
  logic        lock;
  logic        marker;
  logic [1:0]  mid;
  logic        bip_bad;
  logic [15:0] mi;
  logic        found;
  logic        synced;
  logic        sync_err;
  logic [1:0]  id;
  logic        spc_err;
  logic        bip_err;

  modport lane (input word, lock, marker, mid, bip_bad, mi,
                output found, synced, sync_err, id, spc_err, bip_err);
  modport top  (output word, lock, marker, mid, bip_bad, mi,
                input found, synced, sync_err, id, spc_err, bip_err);
endinterface

`default_nettype wire

/* File: rtl/plas_lane.sv */
// marker tracker for one physical receive lane
`default_nettype none

module plas_lane
  import plas_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_in,
  plas_lane_if.lane l
);

  plas_lane_st_t q;
  plas_lane_st_t n;

  // ----------------------------------------------------------
  // marker spacing and lock tracking, stepped once per word
  // ----------------------------------------------------------
  always_comb begin
    n = q;
    n.spc_err = 1'b0;
    n.bip_err = 1'b0;
    if (l.word) begin
      if (!l.lock) begin
        // losing the word boundary forgets every marker seen
        n.cnt   = '0;
        n.seen  = 1'b0;
        n.found = 1'b0;
      end else if (l.marker) begin
        n.cnt  = '0;
        n.seen = 1'b1;
        n.id   = l.mid;
        n.bip_err = l.bip_bad;
        if (q.seen && q.cnt != l.mi) begin
          n.spc_err = 1'b1;
          n.found   = 1'b0;   // relocked by the next good marker
        end else begin
          n.found = 1'b1;
        end
      end else begin
        n.cnt = q.cnt + 16'h0001;
      end
      n.synced   = l.lock & n.seen;
      n.sync_err = ~(l.lock & n.seen);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign l.found    = q.found;
  assign l.synced   = q.synced;
  assign l.sync_err = q.sync_err;
  assign l.id       = q.id;
  assign l.spc_err  = q.spc_err;
  assign l.bip_err  = q.bip_err;

endmodule

`default_nettype wire

/* File: rtl/plas_top.sv */
// lane alignment status block: receive flags, transmit flags, registers
`include "plas_consts.svh"
`default_nettype none

module plas_top
  import plas_pkg::*;
#(
  parameter int SKEW_WORDS = 32,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // ahb-lite register port
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  // receive link pins
  input  wire logic        rx_link_clk_in,
  input  wire logic [3:0]  rx_hdr_lock_in,
  input  wire logic [3:0]  rx_hdr_err_in,
  input  wire logic [3:0]  rx_marker_in,
  input  wire logic [7:0]  rx_marker_lane_in,
  input  wire logic [3:0]  rx_bip_bad_in,
  // transmit clock compensation fifo activity
  input  wire logic        tx_fifo_push_in,
  input  wire logic        tx_fifo_pop_in,
  // receive status
  output logic             rx_aligned_out,
  output logic             rx_align_loss_out,
  output logic             rx_align_err_out,
  output logic             rx_pcs_status_out,
  output logic             rx_high_error_rate_out,
  output logic [3:0]       rx_marker_found_vec_out,
  output logic [1:0]       rx_lane0_phys_map_out,
  output logic [1:0]       rx_lane1_phys_map_out,
  output logic [1:0]       rx_lane2_phys_map_out,
  output logic [1:0]       rx_lane3_phys_map_out,
  output logic [3:0]       rx_bip_err_out,
  output logic [3:0]       rx_word_sync_out,
  output logic [3:0]       rx_word_sync_err_out,
  output logic [3:0]       rx_marker_spacing_err_out,
  // transmit status
  output logic             tx_encoder_init_out,
  output logic             tx_fifo_err_out,
  // interrupt
  output logic             irq_out
);

  plas_top_st_t q;
  plas_top_st_t n;

  // ----------------------------------------------------------
  // synchronised link view
  // ----------------------------------------------------------
  logic       word;
  logic [3:0] lock;
  logic [3:0] herr;
  logic [3:0] mk;
  logic [3:0] bipb;
  logic [7:0] mid;
  logic       all_lock;

  // one word per rising link clock edge seen through the synchroniser
  assign word     = q.lclk_s2 & ~q.lclk_p;
  assign lock     = q.in_s2[3:0];
  assign herr     = q.in_s2[7:4];
  assign mk       = q.in_s2[11:8];
  assign bipb     = q.in_s2[15:12];
  assign mid      = q.in_s2[23:16];
  assign all_lock = &lock;

  // ----------------------------------------------------------
  // physical lane trackers
  // ----------------------------------------------------------
  logic [3:0] l_found;
  logic [3:0] l_sync;
  logic [3:0] l_serr;
  logic [7:0] l_id;
  logic [3:0] l_spc;
  logic [3:0] l_bip;

  for (genvar p = 0; p < `PLAS_LANE_COUNT; p++) begin : g_lane
    plas_lane_if lif ();
    assign lif.word    = word;
    assign lif.lock    = lock[p];
    assign lif.marker  = mk[p];
    assign lif.mid     = mid[2*p +: 2];
    assign lif.bip_bad = bipb[p];
    assign lif.mi      = q.mi;
    assign l_found[p]      = lif.found;
    assign l_sync[p]       = lif.synced;
    assign l_serr[p]       = lif.sync_err;
    assign l_id[2*p +: 2]  = lif.id;
    assign l_spc[p]        = lif.spc_err;
    assign l_bip[p]        = lif.bip_err;
    plas_lane u_lane (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .l        (lif.lane)
    );
  end

  // ----------------------------------------------------------
  // ahb-lite decode helpers
  // ----------------------------------------------------------
  logic        accept;
  logic [31:0] rd_mux;
  logic [11:0] ev;

  // hsize is not checked: only whole-word single transfers are used
  assign accept = hsel_in & htrans_in[1] & hready_in;

  // read view; unmapped offsets read as zero
  always_comb begin
    unique case (q.addr)
      `PLAS_OFF_CTRL:     rd_mux = {31'h0, q.txen};
      `PLAS_OFF_INTERVAL: rd_mux = {16'h0, q.mi};
      `PLAS_OFF_STATUS:   rd_mux = {14'h0, l_serr, l_sync, q.found,
                                    q.ferr, q.txst == PLAS_TX_INIT,
                                    q.hiber, q.pst, q.loss, q.aligned};
      `PLAS_OFF_MAP:      rd_mux = {24'h0, q.map};
      `PLAS_OFF_ISTAT:    rd_mux = {20'h0, q.istat};
      `PLAS_OFF_IMASK:    rd_mux = {20'h0, q.imask};
      default:            rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    n = q;
    // synchronisers: first stage feeds only the second
    n.lclk_s1 = rx_link_clk_in;
    n.lclk_s2 = q.lclk_s1;
    n.lclk_p  = q.lclk_s2;
    n.in_s1   = {rx_marker_lane_in, rx_bip_bad_in, rx_marker_in,
                 rx_hdr_err_in, rx_hdr_lock_in};
    n.in_s2   = q.in_s1;

    n.aerr = 1'b0;

    n.found = '0;
    n.map   = '0;
    n.bip   = '0;
    n.spc   = '0;
    for (int p = 0; p < `PLAS_LANE_COUNT; p++) begin
      for (int c = 0; c < `PLAS_LANE_COUNT; c++) begin
        if (l_found[p] && l_id[2*p +: 2] == 2'(c)) begin
          n.found[c]      = 1'b1;
          n.map[2*c +: 2] = 2'(p);
        end
      end
      // bip pulse routed to pcs lane
      if (l_bip[p]) begin
        n.bip[l_id[2*p +: 2]] = 1'b1;
      end
      // spacing pulse routed to pcs lane
      if (l_spc[p]) begin
        n.spc[l_id[2*p +: 2]] = 1'b1;
      end
    end

    // alignment and deskew, stepped once per word
    if (word) begin
      if (!all_lock) begin
        n.seen_acc = '0;
        n.started  = 1'b0;
        n.win      = '0;
        n.miss     = 1'b0;
      end else begin
        // arm only after all lanes saw a marker
        n.seen_acc = q.seen_acc | mk;
        n.started  = q.started | (&n.seen_acc);
        if (q.win == 7'h0) begin
          // a marker opens the deskew window unless all came at once
          if (|mk && !(&mk)) begin
            n.win = 7'(SKEW_WORDS);
            n.got = mk;
          end else if (&mk) begin
            n.miss = 1'b0;
          end
        end else begin
          n.got = q.got | mk;
          if (&n.got) begin
            n.win  = '0;
            n.miss = 1'b0;
          end else if (q.win == 7'h1) begin
            n.win = '0;
            if (q.started) begin
              n.aerr = 1'b1;
              n.miss = 1'b1;
            end
          end else begin
            n.win = q.win - 7'h1;
          end
        end
      end
      n.aligned = all_lock & (&q.found) & ~n.miss;
      // loss on error or lost alignment
      if (n.aerr || (q.aligned && !n.aligned)) begin
        n.loss = 1'b1;
      end else if (n.aligned && !q.aligned) begin
        n.loss = 1'b0;
      end
    end

    if (q.btmr == 12'(`PLAS_HBER_WIN_CYC - 1)) begin
      n.btmr = '0;
      n.bcnt = '0;
      if (q.bcnt < 5'(`PLAS_HBER_LIMIT)) begin
        n.hiber = 1'b0;
      end
    end else begin
      n.btmr = q.btmr + 12'h001;
      if (word && q.bcnt < 5'(`PLAS_HBER_LIMIT)) begin
        n.bcnt = q.bcnt + 5'($countones(herr & lock));
        if (n.bcnt >= 5'(`PLAS_HBER_LIMIT)) begin
          n.bcnt  = 5'(`PLAS_HBER_LIMIT);
          n.hiber = 1'b1;
        end
      end
    end
    n.pst = n.aligned & ~n.hiber;

    if (tx_fifo_push_in && !tx_fifo_pop_in) begin
      if (q.flvl == 5'(FIFO_DEPTH)) begin
        n.ferr = 1'b1;
      end else begin
        n.flvl = q.flvl + 5'h01;
      end
    end else if (tx_fifo_pop_in && !tx_fifo_push_in) begin
      if (q.flvl == 5'h0) begin
        n.ferr = 1'b1;
      end else begin
        n.flvl = q.flvl - 5'h01;
      end
    end

    unique case (q.txst)
      PLAS_TX_INIT: if (q.txen && !q.ferr) n.txst = PLAS_TX_RUN;
      PLAS_TX_RUN:  if (!q.txen || q.ferr) n.txst = PLAS_TX_INIT;
    endcase

    // ahb-lite: one wait state, then the answer
    ev = '0;
    ev[`PLAS_IRQ_ALIGN]      = n.aerr;
    ev[`PLAS_IRQ_LOSS]       = n.loss & ~q.loss;
    ev[`PLAS_IRQ_TXFIFO]     = n.ferr & ~q.ferr;
    ev[`PLAS_IRQ_BIP +: 4]   = n.bip;
    ev[`PLAS_IRQ_SPC +: 4]   = n.spc;
    if (q.dp && !q.done) begin
      n.done = 1'b1;
      if (q.wr) begin
        unique case (q.addr)
          `PLAS_OFF_CTRL:     n.txen  = hwdata_in[`PLAS_CTRL_TXEN];
          `PLAS_OFF_INTERVAL: n.mi    = hwdata_in[15:0];
          `PLAS_OFF_IMASK:    n.imask = hwdata_in[11:0];
          default:            ;
        endcase
      end else begin
        n.rdata = rd_mux;
        // read of the interrupt status register clears it
        if (q.addr == `PLAS_OFF_ISTAT) begin
          n.istat = '0;
        end
      end
    end else if (q.done) begin
      n.dp   = 1'b0;
      n.done = 1'b0;
    end
    if (accept) begin
      n.dp   = 1'b1;
      n.done = 1'b0;
      n.addr = {haddr_in[7:2], 2'b00};
      n.wr   = hwrite_in;
    end
    // a new event wins over the read clear
    n.istat = n.istat | ev;
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  // flags clear on reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q    <= '0;
      q.mi <= `PLAS_MI_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign hreadyout_out             = ~q.dp | q.done;
  assign hrdata_out                = q.rdata;
  assign hresp_out                 = 1'b0;
  assign rx_aligned_out            = q.aligned;
  assign rx_align_loss_out         = q.loss;
  assign rx_align_err_out          = q.aerr;
  assign rx_pcs_status_out         = q.pst;
  assign rx_high_error_rate_out    = q.hiber;
  assign rx_marker_found_vec_out   = q.found;
  assign rx_lane0_phys_map_out     = q.map[1:0];
  assign rx_lane1_phys_map_out     = q.map[3:2];
  assign rx_lane2_phys_map_out     = q.map[5:4];
  assign rx_lane3_phys_map_out     = q.map[7:6];
  assign rx_bip_err_out            = q.bip;
  assign rx_word_sync_out          = l_sync;
  assign rx_word_sync_err_out      = l_serr;
  assign rx_marker_spacing_err_out = q.spc;
  assign tx_encoder_init_out       = (q.txst == PLAS_TX_INIT);
  // error stays until the port is reset
  assign tx_fifo_err_out           = q.ferr;
  // level interrupt from sticky status and mask
  assign irq_out                   = |(q.istat & q.imask);

endmodule

`default_nettype wire

/* File: tb/plas_top_properties.sv */
// concurrent checks on the ports of the lane alignment status block
`default_nettype none

module plas_top_properties (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hready_in,
  input wire logic       hreadyout_out,
  input wire logic       rx_aligned_out,
  input wire logic       rx_align_loss_out,
  input wire logic       rx_align_err_out,
  input wire logic       rx_pcs_status_out,
  input wire logic       rx_high_error_rate_out,
  input wire logic [3:0] rx_marker_found_vec_out,
  input wire logic [1:0] rx_lane0_phys_map_out,
  input wire logic [1:0] rx_lane1_phys_map_out,
  input wire logic [1:0] rx_lane2_phys_map_out,
  input wire logic [1:0] rx_lane3_phys_map_out,
  input wire logic [3:0] rx_bip_err_out,
  input wire logic [3:0] rx_word_sync_out,
  input wire logic [3:0] rx_word_sync_err_out,
  input wire logic [3:0] rx_marker_spacing_err_out,
  input wire logic       tx_encoder_init_out,
  input wire logic       tx_fifo_err_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------
  // one clock domain, reset stops every check
  // ------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_align_err_pulse: assert property (
    rx_align_err_out |=> !rx_align_err_out) else $error("align error too wide");
  chk_bip_pulse: assert property (
    (rx_bip_err_out & $past(rx_bip_err_out)) == 4'h0)
    else $error("bip error too wide");
  chk_spacing_pulse: assert property (
    |rx_marker_spacing_err_out |=> rx_marker_spacing_err_out == 4'h0)
    else $error("spacing error too wide");
  // status follows aligned and error rate, one cycle slack
  chk_pcs_status: assert property (
    rx_pcs_status_out == (rx_aligned_out && !rx_high_error_rate_out) ||
    rx_pcs_status_out == $past(rx_aligned_out && !rx_high_error_rate_out))
    else $error("pcs status mismatch");
  chk_loss_follows: assert property (
    $rose(rx_align_err_out) |-> ##[0:20] rx_align_loss_out)
    else $error("loss not raised");
  // map reads zero while lane not found
  chk_map_valid: assert property (
    (rx_marker_found_vec_out[0] || rx_lane0_phys_map_out == 2'h0) &&
    (rx_marker_found_vec_out[1] || rx_lane1_phys_map_out == 2'h0) &&
    (rx_marker_found_vec_out[2] || rx_lane2_phys_map_out == 2'h0) &&
    (rx_marker_found_vec_out[3] || rx_lane3_phys_map_out == 2'h0))
    else $error("map set on lane not found");
  // sync and sync error never both
  chk_sync_excl: assert property (
    (rx_word_sync_out & rx_word_sync_err_out) == 4'h0)
    else $error("sync and sync error both set");
  chk_fifo_sticky: assert property (
    tx_fifo_err_out |=> tx_fifo_err_out) else $error("fifo error dropped");
  // error puts the encoder back in init
  chk_tx_init_err: assert property (
    tx_fifo_err_out |=> tx_encoder_init_out) else $error("encoder not in init");
  // one wait state on every register access
  chk_wait_state: assert property (
    hsel_in && htrans_in[1] && hready_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("wait state wrong");

  cover property (rx_aligned_out);
  cover property (tx_fifo_err_out);
  cover property (|rx_marker_spacing_err_out);
  cover property (rx_high_error_rate_out);
endmodule

bind plas_top plas_top_properties u_props (.*);

`default_nettype wire

/* File: tb/plas_link_model.sv */
// four physical receive lanes sending words and lane markers
`default_nettype none

module plas_link_model #(
  parameter logic [7:0] LANE_IDS = 8'h1b
) (
  output logic       link_clk_out,
  output logic [3:0] lock_out,
  output logic [3:0] marker_out,
  output logic [7:0] ids_out,
  output logic [3:0] bip_out,
  output logic [3:0] err_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock stands low between words
  initial begin
    link_clk_out = 1'b0;
    lock_out = 4'h0;
    marker_out = 4'h0;
    ids_out = ~LANE_IDS;
    bip_out = 4'h0;
    err_out = 4'h0;
  end

  // one 320 ns word, offset so its edges never meet the system clock;
  // lanes change by nonblocking assignment so a word begun on a system
  // clock edge never races the block's input flops
  task automatic word(input logic [3:0] lk, mk, bp, er);
    lock_out <= lk;
    marker_out <= mk;
    ids_out <= LANE_IDS;
    bip_out <= bp;
    err_out <= er;
    #93 link_clk_out <= 1'b1;
    #160 link_clk_out <= 1'b0;
    // hold spent: scramble qualifiers so stale values are never trusted
    ids_out <= ~LANE_IDS;
    bip_out <= ~bp;
    #67;
  endtask
endmodule

`default_nettype wire

/* File: tb/plas_top_tb_top.sv */
// self-checking bench for the lane alignment status block
`include "plas_consts.svh"
`default_nettype none

module plas_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_in, hsel_in, hwrite_in, hready_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic        hreadyout_out, hresp_out, rx_link_clk_in, irq_out;
  logic [3:0]  rx_hdr_lock_in, rx_hdr_err_in, rx_marker_in, rx_bip_bad_in;
  logic [7:0]  rx_marker_lane_in;
  logic        tx_fifo_push_in, tx_fifo_pop_in, tx_encoder_init_out;
  logic        rx_aligned_out, rx_align_loss_out, rx_align_err_out;
  logic        rx_pcs_status_out, rx_high_error_rate_out, tx_fifo_err_out;
  logic [1:0]  rx_lane0_phys_map_out, rx_lane1_phys_map_out;
  logic [1:0]  rx_lane2_phys_map_out, rx_lane3_phys_map_out;
  logic [3:0]  rx_marker_found_vec_out, rx_bip_err_out, rx_word_sync_out;
  logic [3:0]  rx_word_sync_err_out, rx_marker_spacing_err_out;
  int          err_count, checked, bip_pulses = 0, spc_pulses = 0;

  assign hready_in = hreadyout_out;
  plas_top #(.SKEW_WORDS(8), .FIFO_DEPTH(16)) dut (.*);
  plas_link_model link (.link_clk_out(rx_link_clk_in),
    .lock_out(rx_hdr_lock_in), .marker_out(rx_marker_in),
    .ids_out(rx_marker_lane_in), .bip_out(rx_bip_bad_in),
    .err_out(rx_hdr_err_in));

  // clock and pulse counter
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // pulse counters: every bip and spacing pulse is counted, never just seen once
  always @(posedge clk_in) begin
    bip_pulses <= bip_pulses + $countones(rx_bip_err_out);
    spc_pulses <= spc_pulses + $countones(rx_marker_spacing_err_out);
  end

  // ---------------------------------
  // tasks
  // ---------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ahb single word; waits on the answer, the watchdog bounds it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'b10;
    hwrite_in <= w;
    hsize_in <= 3'b010;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rd = hrdata_out;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    check($sformatf("reg %h", a), v & m, exp);
  endtask
  task automatic frames(input int n, input logic [3:0] mk, bp);
    repeat (n) begin
      link.word(4'hf, mk, bp, 4'h0);
      repeat (7) link.word(4'hf, 4'h0, 4'h0, 4'h0);
    end
  endtask
  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog
  initial begin
    #3ms;
    err_count++;
    tally_and_finish();
  end

  // ---------------------------------
  // test sequence
  // ---------------------------------
  initial begin
    int p;
    {hsel_in, haddr_in, htrans_in, hwrite_in, hsize_in, hwdata_in} = '0;
    {tx_fifo_push_in, tx_fifo_pop_in, err_count, checked} = '0;
    reset_in = 1'b1;
    do_reset();
    check("flags", {rx_aligned_out, rx_align_loss_out, tx_fifo_err_out,
      irq_out, tx_encoder_init_out}, 32'h1);
    reg_rd(`PLAS_OFF_CTRL, 32'hffffffff, 32'h0);
    reg_rd(`PLAS_OFF_INTERVAL, 32'hffffffff, `PLAS_MI_RST);
    reg_rd(`PLAS_OFF_IMASK, 32'hffffffff, 32'h0);
    reg_rd(8'h18, 32'hffffffff, 32'h0);
    reg_wr(`PLAS_OFF_INTERVAL, 32'h7);
    reg_wr(`PLAS_OFF_IMASK, 32'h80);
    $display("test reset done");
    // lane 3 never sees a marker
    frames(2, 4'h7, 4'h0);
    reg_rd(`PLAS_OFF_ISTAT, 32'h1, 32'h0);
    check("sync err", rx_word_sync_err_out, 32'h8);
    check("sync", rx_word_sync_out, 32'h7);
    frames(3, 4'hf, 4'h0);
    check("found", rx_marker_found_vec_out, 32'hf);
    check("map", {rx_lane3_phys_map_out, rx_lane2_phys_map_out,
      rx_lane1_phys_map_out, rx_lane0_phys_map_out}, 32'h1b);
    check("aligned", rx_aligned_out, 32'h1);
    check("pcs", rx_pcs_status_out, 32'h1);
    check("sync", rx_word_sync_out, 32'hf);
    reg_rd(`PLAS_OFF_MAP, 32'hffffffff, 32'h1b);
    reg_rd(`PLAS_OFF_STATUS, 32'hffffffff, 32'h3fd5);
    reg_rd(`PLAS_OFF_ISTAT, 32'hffffffff, 32'h0);
    $display("test align done");
    // bip per lane, only lane 3 unmasked
    for (p = 0; p < 4; p++) begin
      frames(1, 4'hf, 4'(1 << p));
      check("irq", irq_out, 32'(p == 0));
      reg_rd(`PLAS_OFF_ISTAT, 32'hffffffff, 32'h1 << (7 - p));
      check("irq clr", irq_out, 32'h0);
    end
    check("bip pulses", bip_pulses, 32'h4);
    $display("test bip done");
    // early marker on pcs lane 1
    link.word(4'hf, 4'hf, 4'h0, 4'h0);
    repeat (3) link.word(4'hf, 4'h0, 4'h0, 4'h0);
    link.word(4'hf, 4'h4, 4'h0, 4'h0);
    repeat (3) link.word(4'hf, 4'h0, 4'h0, 4'h0);
    frames(2, 4'hf, 4'h0);
    check("irq", irq_out, 32'h0);
    reg_rd(`PLAS_OFF_ISTAT, 32'hf00, 32'h200);
    check("spc pulses", spc_pulses, 32'h2);
    check("realign", rx_aligned_out, 32'h1);
    $display("test spacing done");
    repeat (4) link.word(4'hf, 4'h0, 4'h0, 4'hf);
    repeat (4) @(posedge clk_in);
    check("hiber", rx_high_error_rate_out, 32'h1);
    check("pcs", rx_pcs_status_out, 32'h0);
    $display("test hiber done");
    frames(2, 4'hd, 4'h0);
    check("aligned", rx_aligned_out, 32'h0);
    check("loss", rx_align_loss_out, 32'h1);
    reg_rd(`PLAS_OFF_ISTAT, 32'h3, 32'h3);
    $display("test misalign done");
    reg_wr(`PLAS_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk_in);
    check("tx init", tx_encoder_init_out, 32'h0);
    tx_fifo_pop_in <= 1'b1;
    @(posedge clk_in);
    tx_fifo_pop_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("fifo err", tx_fifo_err_out, 32'h1);
    check("tx init", tx_encoder_init_out, 32'h1);
    reg_rd(`PLAS_OFF_ISTAT, 32'h4, 32'h4);
    do_reset();
    check("fifo err", tx_fifo_err_out, 32'h0);
    tx_fifo_push_in <= 1'b1;
    repeat (17) @(posedge clk_in);
    tx_fifo_push_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("overflow", tx_fifo_err_out, 32'h1);
    $display("test tx done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
